// >>> common/ifc_pkg.sv
`default_nettype none
package ifc_pkg;

  // slot count and flag layout
  localparam int NUM_SLOTS = 29;
  localparam int NUM_PINS = 8;
  localparam logic [31:0] FLAG_VALID = 32'h1fff_ffff;

  // word indices of the flag registers, byte address is four times the index
  localparam logic [9:0] IDX_REQ_FLAGS_G0_LO = 10'h000;
  localparam logic [9:0] IDX_REQ_FLAGS_G0_HI = 10'h001;
  localparam logic [9:0] IDX_REQ_FLAGS_G1_LO = 10'h002;
  localparam logic [9:0] IDX_REQ_FLAGS_G1_HI = 10'h003;
  localparam logic [9:0] IDX_MASK_FLAGS_G0_LO = 10'h004;
  localparam logic [9:0] IDX_MASK_FLAGS_G0_HI = 10'h005;
  localparam logic [9:0] IDX_MASK_FLAGS_G1_LO = 10'h006;
  localparam logic [9:0] IDX_MASK_FLAGS_G1_HI = 10'h007;
  localparam logic [9:0] IDX_PRIO_FLAGS_G0_LO = 10'h008;
  localparam logic [9:0] IDX_PRIO_FLAGS_G0_HI = 10'h009;
  localparam logic [9:0] IDX_PRIO_FLAGS_G1_LO = 10'h00a;
  localparam logic [9:0] IDX_PRIO_FLAGS_G1_HI = 10'h00b;
  localparam logic [9:0] IDX_RISE_EDGE_ENABLE = 10'h00c;
  localparam logic [9:0] IDX_FALL_EDGE_ENABLE = 10'h00d;
  localparam logic [9:0] IDX_PROGRAM_STATUS_WORD = 10'h00e;
  localparam logic [9:0] IDX_INT_STATUS = 10'h010;
  localparam logic [9:0] IDX_INT_MASK = 10'h011;

  // values after reset
  localparam logic [31:0] REQ_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'hffff_ffff;
  localparam logic [31:0] PRIO_RST = 32'hffff_ffff;
  localparam logic [7:0] EDGE_RST = 8'h00;
  localparam logic [7:0] PSW_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;

  // status word bits
  localparam int PSW_IE_BIT = 7;
  localparam int PSW_ISP_BIT = 1;

  // interrupt status bits
  localparam int INT_BITS = 2;
  localparam int ST_ACK_BIT = 0;
  localparam int ST_FLAG_BIT = 1;

  // special slots
  localparam int SLOT_TIMER_B1 = 24;
  localparam int SLOT_AUX0 = 14;
  localparam int SLOT_AUX1 = 23;
  // pin n feeds slot PIN_SLOT[n]
  localparam logic [7:0][4:0] PIN_SLOT = {5'h10, 5'h0f, 5'h06, 5'h05,
                                          5'h04, 5'h03, 5'h02, 5'h01};

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
`default_nettype wire

// >>> hw/ifc_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_pin_edge
  import ifc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins and edge selection
  input wire logic [NUM_PINS-1:0] pin,
  input wire logic [NUM_PINS-1:0] rise_en,
  input wire logic [NUM_PINS-1:0] fall_en,
  // one-cycle edge events
  output logic [NUM_PINS-1:0] edge_evt
);

  typedef struct packed {
    logic [NUM_PINS-1:0] prev;
    logic primed;
  } ifc_edge_s;

  ifc_edge_s q_r;
  ifc_edge_s q_nxt;

  // remember last level, no edge before the first sample
  always_comb begin
    q_nxt = q_r;
    q_nxt.prev = pin;
    q_nxt.primed = 1'b1;
    edge_evt = '0;
    if (q_r.primed) begin
      edge_evt = (pin & ~q_r.prev & rise_en) | (~pin & q_r.prev & fall_en);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

endmodule // ifc_pin_edge
`default_nettype wire

// >>> hw/ifc_prio_pick.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_prio_pick
  import ifc_pkg::*;
(
  // unmasked pending flags and priority group flags
  input wire logic [NUM_SLOTS-1:0] pend,
  input wire logic [NUM_SLOTS-1:0] prio,
  // chosen slot
  output logic valid,
  output logic [4:0] idx,
  output logic high
);

  // high group first, then lowest slot number within a group
  always_comb begin
    valid = 1'b0;
    idx = 5'h00;
    high = 1'b0;
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (pend[i] && prio[i] && !high) begin
        valid = 1'b1;
        idx = 5'(i);
      end
    end
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      if (pend[i] && !prio[i]) begin
        valid = 1'b1;
        high = 1'b1;
        idx = 5'(i);
      end
    end
  end

endmodule // ifc_prio_pick
`default_nettype wire

// >>> hw/ifc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_top
  import ifc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // request sources
  input wire logic [NUM_SLOTS-1:0] periph_req,
  input wire logic [1:0] aux_req,
  input wire logic carrier_mode_irq,
  input wire logic timer_b1_carrier_mode,
  input wire logic [NUM_PINS-1:0] ext_pin,
  // processor core
  output logic core_irq,
  output logic [4:0] core_irq_idx,
  output logic core_irq_high,
  input wire logic core_ack,
  // interrupt to software
  output logic irq
);

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_full;
    logic w_full;
    logic [31:0] awaddr;
    logic [7:0] wbyte;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] req;
    logic [31:0] mask;
    logic [31:0] prio;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] program_status_word;
    logic [INT_BITS-1:0] int_status;
    logic [INT_BITS-1:0] int_mask;
    logic irq;
    logic core_irq;
    logic [4:0] core_idx;
    logic core_high;
  } ifc_top_s;

  ifc_top_s q_r;
  ifc_top_s q_nxt;

  logic [NUM_PINS-1:0] pin_evt;
  logic [31:0] hw_set;
  logic pick_valid;
  logic [4:0] pick_idx;
  logic pick_high;

  // word index of an aligned address inside the map, bit 10 marks a hit
  function automatic logic [10:0] word_idx(input logic [31:0] addr);
    logic hit;
    hit = (addr[31:12] == 20'h00000) && (addr[1:0] == 2'h0);
    word_idx = {hit, addr[11:2]};
  endfunction

  // byte lane of a four-register flag group
  function automatic logic [4:0] lane_lsb(input logic [9:0] idx);
    lane_lsb = {idx[1:0], 3'h0};
  endfunction

  // register hit test, the flag groups take four words each
  function automatic logic map_hit(input logic [10:0] wi);
    map_hit = wi[10] && ((wi[9:0] <= IDX_PROGRAM_STATUS_WORD) ||
                         (wi[9:0] == IDX_INT_STATUS) || (wi[9:0] == IDX_INT_MASK));
  endfunction

  // read view of one word
  function automatic logic [31:0] rd_word(input logic [9:0] idx, input ifc_top_s s);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (idx <= IDX_REQ_FLAGS_G1_HI) begin
      v[7:0] = s.req[lane_lsb(idx) +: 8];
    end else if (idx <= IDX_MASK_FLAGS_G1_HI) begin
      v[7:0] = s.mask[lane_lsb(idx) +: 8];
    end else if (idx <= IDX_PRIO_FLAGS_G1_HI) begin
      v[7:0] = s.prio[lane_lsb(idx) +: 8];
    end else if (idx == IDX_RISE_EDGE_ENABLE) begin
      v[7:0] = s.rise;
    end else if (idx == IDX_FALL_EDGE_ENABLE) begin
      v[7:0] = s.fall;
    end else if (idx == IDX_PROGRAM_STATUS_WORD) begin
      v[7:0] = s.program_status_word;
    end else if (idx == IDX_INT_STATUS) begin
      v[INT_BITS-1:0] = s.int_status;
    end else if (idx == IDX_INT_MASK) begin
      v[INT_BITS-1:0] = s.int_mask;
    end
    rd_word = v;
  endfunction

  // external pin edge detection
  ifc_pin_edge u_pin_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(ext_pin),
    .rise_en(q_r.rise),
    .fall_en(q_r.fall),
    .edge_evt(pin_evt)
  );

  // fixed-order choice among unmasked pending slots
  ifc_prio_pick u_prio_pick (
    .pend(q_r.req[NUM_SLOTS-1:0] & ~q_r.mask[NUM_SLOTS-1:0]),
    .prio(q_r.prio[NUM_SLOTS-1:0]),
    .valid(pick_valid),
    .idx(pick_idx),
    .high(pick_high)
  );

  // per-slot set events, the aux slots take either source, the timer B1 slot takes the one chosen by timer_b1_carrier_mode
  always_comb begin
    hw_set = 32'h0000_0000;
    hw_set[NUM_SLOTS-1:0] = periph_req;
    hw_set[SLOT_TIMER_B1] = timer_b1_carrier_mode ? carrier_mode_irq
                                                  : periph_req[SLOT_TIMER_B1];
    hw_set[SLOT_AUX0] = periph_req[SLOT_AUX0] | aux_req[0];
    hw_set[SLOT_AUX1] = periph_req[SLOT_AUX1] | aux_req[1];
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_evt[i]) begin
        hw_set[PIN_SLOT[i]] = 1'b1;
      end
    end
  end

  // next state: bus slave, flag updates, core presentation
  always_comb begin
    logic [10:0] wi;
    logic [10:0] ri;
    logic ack_now;
    logic accept;
    wi = word_idx(q_r.awaddr);
    ri = word_idx(araddr);
    ack_now = core_ack && q_r.core_irq;
    accept = 1'b0;
    q_nxt = q_r;

    // write address and data are taken in either order
    if (q_r.awready && awvalid) begin
      q_nxt.awready = 1'b0;
      q_nxt.aw_full = 1'b1;
      q_nxt.awaddr = awaddr;
    end
    if (q_r.wready && wvalid) begin
      q_nxt.wready = 1'b0;
      q_nxt.w_full = 1'b1;
      q_nxt.wbyte = wdata[7:0];
      q_nxt.wlane = wstrb[0];
    end

    // perform a write once both halves are held
    if (q_r.aw_full && q_r.w_full && !q_r.bvalid) begin
      q_nxt.aw_full = 1'b0;
      q_nxt.w_full = 1'b0;
      q_nxt.bvalid = 1'b1;
      q_nxt.bresp = map_hit(wi) ? RESP_OKAY : RESP_SLVERR;
      if (map_hit(wi) && q_r.wlane) begin
        if (wi[9:0] <= IDX_REQ_FLAGS_G1_HI) begin
          q_nxt.req[lane_lsb(wi[9:0]) +: 8] = q_r.wbyte;
        end else if (wi[9:0] <= IDX_MASK_FLAGS_G1_HI) begin
          q_nxt.mask[lane_lsb(wi[9:0]) +: 8] = q_r.wbyte;
        end else if (wi[9:0] <= IDX_PRIO_FLAGS_G1_HI) begin
          q_nxt.prio[lane_lsb(wi[9:0]) +: 8] = q_r.wbyte;
        end else if (wi[9:0] == IDX_RISE_EDGE_ENABLE) begin
          q_nxt.rise = q_r.wbyte;
        end else if (wi[9:0] == IDX_FALL_EDGE_ENABLE) begin
          q_nxt.fall = q_r.wbyte;
        end else if (wi[9:0] == IDX_PROGRAM_STATUS_WORD) begin
          q_nxt.program_status_word = q_r.wbyte;
        end else if (wi[9:0] == IDX_INT_STATUS) begin
          q_nxt.int_status = q_r.int_status & ~q_r.wbyte[INT_BITS-1:0];
        end else if (wi[9:0] == IDX_INT_MASK) begin
          q_nxt.int_mask = q_r.wbyte[INT_BITS-1:0];
        end
      end
    end
    if (q_r.bvalid && bready) begin
      q_nxt.bvalid = 1'b0;
      q_nxt.awready = 1'b1;
      q_nxt.wready = 1'b1;
    end

    // read answers one cycle after the address is taken
    if (q_r.arready && arvalid) begin
      q_nxt.arready = 1'b0;
      q_nxt.rvalid = 1'b1;
      q_nxt.rresp = map_hit(ri) ? RESP_OKAY : RESP_SLVERR;
      q_nxt.rdata = map_hit(ri) ? rd_word(ri[9:0], q_r) : 32'h0000_0000;
    end
    if (q_r.rvalid && rready) begin
      q_nxt.rvalid = 1'b0;
      q_nxt.arready = 1'b1;
    end

    // acknowledge clears the served flag and closes the gate
    if (ack_now) begin
      q_nxt.req[q_r.core_idx] = 1'b0;
      q_nxt.program_status_word[PSW_IE_BIT] = 1'b0;
      if (q_r.core_high) begin
        q_nxt.program_status_word[PSW_ISP_BIT] = 1'b1;
      end
    end

    // a new request beats a clear in the same cycle
    q_nxt.req = (q_nxt.req | hw_set) & FLAG_VALID;
    q_nxt.int_status[ST_ACK_BIT] = q_nxt.int_status[ST_ACK_BIT] | ack_now;
    q_nxt.int_status[ST_FLAG_BIT] = q_nxt.int_status[ST_FLAG_BIT] | (|hw_set);
    q_nxt.irq = |(q_r.int_status & q_r.int_mask);

    // present the chosen slot while interrupts are enabled, a low-group slot only while the ISP bit is clear
    accept = q_r.program_status_word[PSW_IE_BIT] && pick_valid &&
             (pick_high || !q_r.program_status_word[PSW_ISP_BIT]);
    q_nxt.core_irq = accept && !ack_now;
    if (accept && !ack_now) begin
      q_nxt.core_idx = pick_idx;
      q_nxt.core_high = pick_high;
    end
  end

  // state register with reset values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
      q_r.awready <= 1'b1;
      q_r.wready <= 1'b1;
      q_r.arready <= 1'b1;
      q_r.req <= REQ_RST;
      q_r.mask <= MASK_RST;
      q_r.prio <= PRIO_RST;
      q_r.rise <= EDGE_RST;
      q_r.fall <= EDGE_RST;
      q_r.program_status_word <= PSW_RST;
      q_r.int_status <= INT_RST;
      q_r.int_mask <= INT_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // outputs straight from the state register
  assign awready = q_r.awready;
  assign wready = q_r.wready;
  assign bvalid = q_r.bvalid;
  assign bresp = q_r.bresp;
  assign arready = q_r.arready;
  assign rvalid = q_r.rvalid;
  assign rresp = q_r.rresp;
  assign rdata = q_r.rdata;
  assign core_irq = q_r.core_irq;
  assign core_irq_idx = q_r.core_idx;
  assign core_irq_high = q_r.core_high;
  assign irq = q_r.irq;

endmodule // ifc_top
`default_nettype wire

// >>> tb/ifc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_core_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request and answer
  input wire logic core_irq,
  input wire logic [1:0] lat,
  output logic core_ack
);
  int cnt;

  // acknowledge after lat waiting cycles, one-cycle pulse
  always @(posedge aclk) begin
    if (!aresetn || !core_irq || core_ack) begin
      cnt <= 0;
      core_ack <= 1'h0;
    end else if (cnt >= int'(lat)) begin
      core_ack <= 1'h1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // ifc_core_model
`default_nettype wire

// >>> tb/ifc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ifc_top_monitor
  import ifc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  // core side
  input wire logic core_irq,
  input wire logic [4:0] core_irq_idx,
  input wire logic core_ack,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // bus timing and core handshake checks
  a_ack_clears: assert property (core_irq && core_ack |=> !core_irq)
    else $error("core request kept after acknowledge");
  a_idx_range: assert property (core_irq |-> core_irq_idx <= 5'h1c)
    else $error("presented slot out of range");
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("no write response");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response not held");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("no read response");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !core_irq && !irq && !bvalid && !rvalid)
    else $error("outputs active after reset");

  // main scenarios
  c_ack: cover property (core_irq && core_ack);
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
endmodule // ifc_top_monitor

bind ifc_top ifc_top_monitor u_ifc_top_monitor (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rvalid, .rready, .core_irq,
  .core_irq_idx, .core_ack, .irq);
`default_nettype wire

// >>> tb/test_ifc_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_ifc_top;
  import ifc_pkg::*;
  // stimulus
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [3:0] wstrb = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [NUM_SLOTS-1:0] periph_req = '0;
  logic [1:0] aux_req = '0, lat = '0;
  logic carrier_mode_irq = 1'h0, timer_b1_carrier_mode = 1'h0;
  logic [7:0] ext_pin = '0;
  // observed
  logic awready, wready, bvalid, arready, rvalid, core_irq, core_irq_high, core_ack, irq;
  logic [1:0] bresp, rresp, rs;
  logic [31:0] rdata, v, e, d;
  logic [4:0] core_irq_idx;
  logic [5:0] ix;
  int n_mismatch = 0, checked = 0, seed = 32'h61922789, r;

  ifc_top u_ifc_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .periph_req, .aux_req, .carrier_mode_irq, .timer_b1_carrier_mode, .ext_pin,
    .core_irq, .core_irq_idx, .core_irq_high, .core_ack, .irq);
  ifc_core_model u_ifc_core_model (.aclk, .aresetn, .core_irq, .lat, .core_ack);

  // clock
  always #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, s, x);
    end
  endtask

  task automatic wr(input logic [9:0] i, input logic [7:0] dd);
    bit g;
    g = 0;
    @(posedge aclk);
    awaddr <= {20'h0, i, 2'h0};
    wdata <= {24'h0, dd};
    wstrb <= 4'h1;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!g) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        chk({30'h0, bresp}, {30'h0, (i <= IDX_PROGRAM_STATUS_WORD || i == IDX_INT_STATUS ||
          i == IDX_INT_MASK) ? RESP_OKAY : RESP_SLVERR});
        bready <= 1'h0;
        g = 1;
      end
    end
  endtask

  task automatic rd(input logic [9:0] i, output logic [31:0] o, output logic [1:0] q);
    bit g;
    g = 0;
    o = 'x;
    @(posedge aclk);
    araddr <= {20'h0, i, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!g) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        o = rdata;
        q = rresp;
        rready <= 1'h0;
        g = 1;
      end
    end
  endtask

  task automatic flags(output logic [31:0] f);
    logic [31:0] b;
    logic [1:0] q;
    for (int k = 0; k < 4; k++) begin
      rd(10'(k), b, q);
      f[8*k +: 8] = b[7:0];
    end
  endtask

  task automatic clr();
    for (int k = 0; k < 4; k++) wr(10'(k), 8'h0);
  endtask

  task automatic pulse(input logic [NUM_SLOTS-1:0] p, input logic [1:0] a, input logic c);
    @(posedge aclk);
    periph_req <= p;
    aux_req <= a;
    carrier_mode_irq <= c;
    @(posedge aclk);
    periph_req <= '0;
    aux_req <= '0;
    carrier_mode_irq <= 1'h0;
  endtask

  // slot first presented, then wait for the acknowledge
  task automatic serve(output logic [5:0] w);
    bit seen;
    bit g;
    seen = 0;
    g = 0;
    w = 'x;
    lat <= 2'($random(seed));
    for (int t = 0; t < 60 && !g; t++) begin
      @(posedge aclk);
      if (core_irq && !seen) begin
        w = {core_irq_high, core_irq_idx};
        seen = 1;
      end
      g = core_irq && core_ack;
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 0; i < 18; i++) begin
      rd(10'(i), d, rs);
      e = (i >= 4 && i < 12) ? 32'hff : 32'h0;
      chk(d, e);
      chk({30'h0, rs}, {30'h0, (i == 15) ? RESP_SLVERR : RESP_OKAY});
    end
    wr(10'h00f, 8'hff);
    for (int n = 0; n < 6; n++) begin
      r = $random(seed);
      v = $random(seed);
      timer_b1_carrier_mode <= r[31];
      pulse(v[NUM_SLOTS-1:0], r[1:0], r[2]);
      e = v & FLAG_VALID;
      if (r[31]) e[SLOT_TIMER_B1] = r[2];
      e[SLOT_AUX0] = e[SLOT_AUX0] | r[0];
      e[SLOT_AUX1] = e[SLOT_AUX1] | r[1];
      flags(d);
      chk(d, e);
      clr();
    end
    v = $random(seed);
    e = '0;
    for (int n = 0; n < 8; n++) if (v[n]) e[PIN_SLOT[n]] = 1'h1;
    wr(IDX_RISE_EDGE_ENABLE, 8'hff);
    ext_pin <= v[7:0];
    repeat (3) @(posedge aclk);
    flags(d);
    chk(d, e);
    clr();
    wr(IDX_RISE_EDGE_ENABLE, 8'h0);
    wr(IDX_FALL_EDGE_ENABLE, 8'hff);
    ext_pin <= 8'h0;
    repeat (3) @(posedge aclk);
    flags(d);
    chk(d, e);
    clr();
    for (int k = 4; k < 8; k++) wr(10'(k), (k == 5) ? 8'h40 : 8'h0);
    wr(IDX_INT_MASK, 8'h1);
    wr(IDX_PROGRAM_STATUS_WORD, 8'h80);
    pulse('0, 2'h1, 1'h0);
    repeat (4) @(posedge aclk);
    chk(32'(core_irq), 32'h0);
    pulse(29'h0100008, 2'h0, 1'h0);
    serve(ix);
    chk(32'(ix), 32'h3);
    flags(d);
    chk(d, 32'h104000);
    rd(IDX_PROGRAM_STATUS_WORD, d, rs);
    chk(d, 32'h0);
    chk(32'(irq), 32'h1);
    wr(IDX_PRIO_FLAGS_G1_LO, 8'hef);
    pulse(29'h8, 2'h0, 1'h0);
    wr(IDX_PROGRAM_STATUS_WORD, 8'h80);
    serve(ix);
    chk(32'(ix), 32'h34);
    rd(IDX_PROGRAM_STATUS_WORD, d, rs);
    chk(d, 32'h2);
    rd(IDX_INT_STATUS, d, rs);
    chk(d, 32'h3);
    wr(IDX_INT_STATUS, 8'h3);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h0);
    conclude();
  end
endmodule // test_ifc_top
`default_nettype wire
